// ### core/prog_fifo.sv
// FIFO with empty, full and programmable almost flags plus offset registers.
// Assumes read and write clocks tied to clk; all pins synchronous to it.
module prog_fifo
  import prog_fifo_pkg::*;
(
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              master_reset_n,
  // Write port
  input  wire logic                              write_enable_primary_n,
  input  wire logic                              write_enable_second_or_load,
  input  wire logic [prog_fifo_pkg::DATA_W-1:0]  write_data_in,
  // Read port
  input  wire logic                              read_enable_a_n,
  input  wire logic                              read_enable_b_n,
  input  wire logic                              output_enable_n,
  output logic [prog_fifo_pkg::DATA_W-1:0]       read_data_out,
  output logic                                   read_data_oe,
  // Flags
  output logic                                   empty_flag_n,
  output logic                                   almost_empty_flag_n,
  output logic                                   full_flag_n,
  output logic                                   almost_full_flag_n,
  // Staging back-pressure
  output logic                                   write_ready
);

  import prog_fifo_pkg::*;

  // Storage
  logic [DATA_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] wptr_q;
  logic [ADDR_W-1:0] wptr_d;
  logic [ADDR_W-1:0] rptr_q;
  logic [ADDR_W-1:0] rptr_d;
  logic [CNT_W-1:0]  arr_cnt_q;
  logic [CNT_W-1:0]  arr_cnt_d;
  logic [CNT_W-1:0]  tot_cnt_q;
  logic [CNT_W-1:0]  tot_cnt_d;

  // Flags and output register
  logic              empty_q;
  logic              empty_d;
  logic              aempty_q;
  logic              aempty_d;
  logic              full_q;
  logic              full_d;
  logic              afull_q;
  logic              afull_d;
  logic [DATA_W-1:0] dout_q;
  logic [DATA_W-1:0] dout_d;

  // Mode and offsets
  logic              mode_q;
  logic              mode_d;
  offset_sel_e       sel_q;
  offset_sel_e       sel_d;
  offset_sel_e       sel_next;
  logic [OFFS_W-1:0] empty_lo_q;
  logic [OFFS_W-1:0] empty_lo_d;
  logic [OFFS_W-1:0] full_lo_q;
  logic [OFFS_W-1:0] full_lo_d;
  logic [OFFS_W-1:0] sel_value;

  // Request decode
  logic              dev_reset;
  logic              load_active;
  logic              rd_both;
  logic              wr_req;
  logic              wr_take;
  logic              rd_take;
  logic              offs_wr;
  logic              offs_rd;
  logic              stage_valid;
  logic              stage_ready;
  logic [DATA_W-1:0] stage_data;
  logic              drain;
  logic [9:0]        n_ext;
  logic [9:0]        m_ext;
  logic [9:0]        arr_ext;
  logic [9:0]        tot_ext;

  assign dev_reset   = rst || !master_reset_n;
  assign load_active = (mode_q == MODE_LOAD) && !write_enable_second_or_load;
  assign rd_both     = !read_enable_a_n && !read_enable_b_n;

  // Word write request by mode
  always_comb begin
    if (mode_q == MODE_DUAL_ENABLE) begin
      wr_req = !write_enable_primary_n && write_enable_second_or_load; // RULE_08
    end else begin
      wr_req = !write_enable_primary_n && write_enable_second_or_load; // RULE_14
    end
  end

  assign wr_take = wr_req && full_q && stage_ready; // RULE_11
  assign rd_take = rd_both && !load_active && empty_q; // RULE_09 RULE_11
  assign offs_wr = load_active && !write_enable_primary_n; // RULE_16
  assign offs_rd = load_active && rd_both; // RULE_18
  assign write_ready = stage_ready;

  stage_fifo #(
    .WIDTH (STAGE_W),
    .DEPTH (STAGE_D)
  ) u_stage (
    .clk       (clk),
    .rst       (dev_reset),
    .in_valid  (wr_take),
    .in_ready  (stage_ready),
    .in_data   (write_data_in),
    .out_valid (stage_valid),
    .out_ready (arr_cnt_q != DEPTH_CNT),
    .out_data  (stage_data)
  );

  assign drain = stage_valid && (arr_cnt_q != DEPTH_CNT);

  // Pointers and occupancy
  always_comb begin
    wptr_d    = drain ? wptr_q + 1'b1 : wptr_q; // RULE_04
    rptr_d    = rd_take ? rptr_q + 1'b1 : rptr_q; // RULE_04
    arr_cnt_d = arr_cnt_q;
    tot_cnt_d = tot_cnt_q;
    if (drain && !rd_take) begin
      arr_cnt_d = arr_cnt_q + 1'b1;
    end else if (rd_take && !drain) begin
      arr_cnt_d = arr_cnt_q - 1'b1;
    end
    if (wr_take && !rd_take) begin
      tot_cnt_d = tot_cnt_q + 1'b1;
    end else if (rd_take && !wr_take) begin
      tot_cnt_d = tot_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (dev_reset) begin
      wptr_q    <= '0;
      rptr_q    <= '0;
      arr_cnt_q <= CNT_ZERO; // RULE_05
      tot_cnt_q <= CNT_ZERO; // RULE_05
    end else begin
      wptr_q    <= wptr_d;
      rptr_q    <= rptr_d;
      arr_cnt_q <= arr_cnt_d;
      tot_cnt_q <= tot_cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (drain) begin
      mem[wptr_q] <= stage_data; // RULE_04
    end
  end

  // Offset sequence advance
  always_comb begin
    unique case (sel_q)
      SEL_EMPTY_LO: sel_next = SEL_EMPTY_HI;
      SEL_EMPTY_HI: sel_next = SEL_FULL_LO;
      SEL_FULL_LO:  sel_next = SEL_FULL_HI;
      SEL_FULL_HI:  sel_next = SEL_EMPTY_LO; // RULE_16
      default:      sel_next = SEL_EMPTY_LO;
    endcase
  end

  // High bytes have no storage at this depth
  always_comb begin
    unique case (sel_q)
      SEL_EMPTY_LO: sel_value = empty_lo_q;
      SEL_EMPTY_HI: sel_value = 8'h00; // RULE_23
      SEL_FULL_LO:  sel_value = full_lo_q;
      SEL_FULL_HI:  sel_value = 8'h00; // RULE_23
      default:      sel_value = 8'h00;
    endcase
  end

  always_comb begin
    mode_d     = mode_q;
    sel_d      = sel_q;
    empty_lo_d = empty_lo_q;
    full_lo_d  = full_lo_q;
    if (!master_reset_n) begin
      mode_d = write_enable_second_or_load; // RULE_13
    end
    if (offs_wr) begin
      unique case (sel_q)
        SEL_EMPTY_LO: empty_lo_d = write_data_in[OFFS_W-1:0]; // RULE_15
        SEL_FULL_LO:  full_lo_d  = write_data_in[OFFS_W-1:0]; // RULE_15
        default:      empty_lo_d = empty_lo_q;
      endcase
    end
    // One step even if both sides access together
    if (offs_wr || offs_rd) begin
      sel_d = sel_next; // RULE_17 RULE_19
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= MODE_DUAL_ENABLE;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge clk) begin
    if (dev_reset) begin
      sel_q      <= SEL_EMPTY_LO; // RULE_22
      empty_lo_q <= OFFSET_DEFAULT; // RULE_01 RULE_22
      full_lo_q  <= OFFSET_DEFAULT; // RULE_01 RULE_22
    end else begin
      sel_q      <= sel_d;
      empty_lo_q <= empty_lo_d;
      full_lo_q  <= full_lo_d;
    end
  end

  // Flags from next occupancy
  assign n_ext   = {2'b00, empty_lo_q};
  assign m_ext   = {2'b00, full_lo_q};
  assign arr_ext = {3'b000, arr_cnt_d};
  assign tot_ext = {3'b000, tot_cnt_d};

  always_comb begin
    empty_d  = (arr_cnt_d != CNT_ZERO);
    aempty_d = (arr_ext > n_ext); // RULE_20
    full_d   = (tot_cnt_d != DEPTH_CNT);
    afull_d  = ((tot_ext + m_ext) < {3'b000, DEPTH_CNT}); // RULE_21
  end

  // Registered flags hold at least a cycle
  always_ff @(posedge clk) begin
    if (dev_reset) begin
      empty_q  <= 1'b0; // RULE_05
      aempty_q <= 1'b0;
      full_q   <= 1'b1;
      afull_q  <= 1'b1;
    end else begin
      empty_q  <= empty_d; // RULE_02 RULE_03
      aempty_q <= aempty_d; // RULE_02 RULE_03
      full_q   <= full_d; // RULE_02 RULE_03
      afull_q  <= afull_d; // RULE_02 RULE_03
    end
  end

  // Output register keeps last valid read
  always_comb begin
    dout_d = dout_q; // RULE_12
    if (rd_take) begin
      dout_d = mem[rptr_q]; // RULE_09
    end else if (offs_rd) begin
      dout_d = {1'b0, sel_value}; // RULE_18
    end
  end

  always_ff @(posedge clk) begin
    if (dev_reset) begin
      dout_q <= DATA_ZERO; // RULE_06
    end else begin
      dout_q <= dout_d;
    end
  end

  assign read_data_out       = dout_q; // RULE_10
  assign read_data_oe        = !output_enable_n; // RULE_10
  assign empty_flag_n        = empty_q;
  assign almost_empty_flag_n = aempty_q;
  assign full_flag_n         = full_q;
  assign almost_full_flag_n  = afull_q;

endmodule : prog_fifo

// ### core/prog_fifo_pkg.sv
// Constants, state codes and offset sequence for the programmable-flag FIFO.
// Assumes a single clock for both ports; both pin groups are synchronous to it.
//
// Contract
// RULE_01: After reset both almost thresholds are seven words until reprogrammed.
// RULE_02: Empty-side flags change on read edges, full-side flags on write edges.
// RULE_03: A flag that changes holds its new value at least one cycle.
// RULE_04: Storage is a dual-port array of 9-bit words, separate read/write pointers.
// RULE_05: Master reset low puts the FIFO empty with empty flag low.
// RULE_06: After reset release all nine read-data outputs are low.
// RULE_07: Outside party resets after power-up and does not transfer during reset.
// RULE_08: Dual-enable mode stores on primary enable low and second enable high.
// RULE_09: Both read enables low presents the next stored word each edge.
// RULE_10: Output enable high floats read data; low drives the output register.
// RULE_11: Writes ignored while full, reads ignored while empty.
// RULE_12: When empty the last validly read word stays on the outputs.
// RULE_13: Mode pin sampled during reset: high second enable, low load select.
// RULE_14: Load mode: primary enable low with load high stores a word.
// RULE_15: Load mode offers four 8-bit offset registers through the data pins.
// RULE_16: Load and primary enable low write offsets in order, wrapping after four.
// RULE_17: Raising load keeps the offset sequence position for the next access.
// RULE_18: Load low and read enables low read offsets out in the same order.
// RULE_19: Outside party should not read and write offsets in the same cycle.
// RULE_20: Almost-empty low while n or fewer words remain, high at n+1.
// RULE_21: Almost-full low at depth minus m words, high when more than m free.
// RULE_22: Reset restores default offsets and points the sequence at empty low byte.
// RULE_23: Only needed high-byte offset bits exist; the rest read as zero.
package prog_fifo_pkg;

  localparam int unsigned DATA_W     = 9;
  localparam int unsigned DEPTH      = 64;
  localparam int unsigned ADDR_W     = 6;
  localparam int unsigned CNT_W      = 7;
  localparam int unsigned OFFS_W     = 8;
  localparam int unsigned HIGH_W     = 0;
  localparam int unsigned STAGE_W    = 9;
  localparam int unsigned STAGE_D    = 16;

  localparam logic [OFFS_W-1:0] OFFSET_DEFAULT = 8'h07;
  localparam logic [CNT_W-1:0]  DEPTH_CNT      = 7'h40;
  localparam logic [CNT_W-1:0]  CNT_ZERO       = 7'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO      = 9'h000;

  // Mode latched at reset
  localparam logic MODE_DUAL_ENABLE = 1'b1;
  localparam logic MODE_LOAD        = 1'b0;

  typedef enum logic [3:0] {
    SEL_EMPTY_LO = 4'b0001,
    SEL_EMPTY_HI = 4'b0010,
    SEL_FULL_LO  = 4'b0100,
    SEL_FULL_HI  = 4'b1000
  } offset_sel_e;

endpackage : prog_fifo_pkg

// ### core/stage_fifo.sv
// Parameterised staging FIFO with valid/ready on both sides.
// Assumes the drain side may hold out_ready low to stall it.
module stage_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    wr_d;
  logic [PW-1:0]    rd_q;
  logic [PW-1:0]    rd_d;
  logic [PW:0]      cnt_q;
  logic [PW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != DEPTH[PW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

endmodule : stage_fifo

// ### sim/prog_fifo_monitor.sv
// Concurrent checks on the programmable-flag FIFO top ports.
// Assumes one clock domain; bound to every prog_fifo instance.
module prog_fifo_monitor
  import prog_fifo_pkg::*;
(
  // Clock and resets
  input wire logic                             clk,
  input wire logic                             rst,
  input wire logic                             master_reset_n,
  // Controls
  input wire logic                             write_enable_primary_n,
  input wire logic                             write_enable_second_or_load,
  input wire logic                             read_enable_a_n,
  input wire logic                             read_enable_b_n,
  input wire logic                             output_enable_n,
  // Outputs
  input wire logic [prog_fifo_pkg::DATA_W-1:0] read_data_out,
  input wire logic                             read_data_oe,
  input wire logic                             empty_flag_n,
  input wire logic                             almost_empty_flag_n,
  input wire logic                             full_flag_n,
  input wire logic                             almost_full_flag_n,
  input wire logic                             write_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_reset_state: assert property (!master_reset_n |=>
    !empty_flag_n && !almost_empty_flag_n && full_flag_n && almost_full_flag_n && read_data_out == DATA_ZERO)
    else $error("reset state wrong");
  chk_oe_follows: assert property (read_data_oe == !output_enable_n)
    else $error("output enable mismatch");
  chk_empty_hold: assert property (!empty_flag_n && write_enable_second_or_load && master_reset_n
    |=> $stable(read_data_out)) else $error("data changed while empty");
  chk_full_flags: assert property (!full_flag_n |-> !almost_full_flag_n)
    else $error("full without almost full");
  chk_empty_flags: assert property (!empty_flag_n |-> !almost_empty_flag_n)
    else $error("empty without almost empty");
  chk_write_fills: assert property (!write_enable_primary_n && write_enable_second_or_load && write_ready
    && full_flag_n && !empty_flag_n && master_reset_n ##1 master_reset_n |=> empty_flag_n)
    else $error("write did not clear empty");
  chk_full_refuse: assert property (!full_flag_n && master_reset_n
    && (read_enable_a_n || read_enable_b_n) |=> !full_flag_n) else $error("full flag lost");
  chk_idle_empty: assert property ((write_enable_primary_n && master_reset_n)[*3] ##0 !empty_flag_n
    |=> !empty_flag_n) else $error("empty flag rose unprompted");
endmodule : prog_fifo_monitor

bind prog_fifo prog_fifo_monitor mon (.clk, .rst, .master_reset_n, .write_enable_primary_n,
  .write_enable_second_or_load, .read_enable_a_n, .read_enable_b_n, .output_enable_n, .read_data_out,
  .read_data_oe, .empty_flag_n, .almost_empty_flag_n, .full_flag_n, .almost_full_flag_n, .write_ready);

// ### sim/fifo_bus_model.sv
// Far-side bus seen by the reader: resolves the three-state read data.
// Assumes the reader samples the bus on clk; a floating bus shows the inverse.
module fifo_bus_model
  import prog_fifo_pkg::*;
(
  input  wire logic                             clk,
  input  wire logic [prog_fifo_pkg::DATA_W-1:0] read_data_out,
  input  wire logic                             read_data_oe,
  output logic [prog_fifo_pkg::DATA_W-1:0]      bus_level
);
  logic [DATA_W-1:0] last_q;
  logic [DATA_W-1:0] last_d;
  always_comb begin
    last_d    = read_data_oe ? read_data_out : last_q;
    bus_level = read_data_oe ? read_data_out : ~last_q;
  end
  always_ff @(posedge clk) begin
    last_q <= last_d;
  end
endmodule : fifo_bus_model

// ### sim/testbench.sv
// Self-checking bench for prog_fifo with random data from an LFSR.
// Assumes the single clock; the far-side bus is resolved by fifo_bus_model.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import prog_fifo_pkg::*;
  logic              clk, rst, mrst_n, wen_n, pin, ren_a_n, ren_b_n, oe_n;
  logic              oe, ef_n, ae_n, ff_n, af_n, wr_rdy;
  logic [DATA_W-1:0] din, dout, bus, last;
  logic [16:0]       lfsr;
  logic [DATA_W-1:0] q[$];
  int                err_count, checked;
  prog_fifo uut (.clk(clk), .rst(rst), .master_reset_n(mrst_n), .write_enable_primary_n(wen_n),
    .write_enable_second_or_load(pin), .write_data_in(din), .read_enable_a_n(ren_a_n),
    .read_enable_b_n(ren_b_n), .output_enable_n(oe_n), .read_data_out(dout), .read_data_oe(oe),
    .empty_flag_n(ef_n), .almost_empty_flag_n(ae_n), .full_flag_n(ff_n), .almost_full_flag_n(af_n),
    .write_ready(wr_rdy));
  fifo_bus_model far (.clk(clk), .read_data_out(dout), .read_data_oe(oe), .bus_level(bus));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [16:0] step(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : step
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task automatic push(input int n, input int m);
    for (int k = 0; k < n; k++) begin
      lfsr = step(lfsr);
      din = lfsr[8:0];
      wen_n = 1'b0;
      if (ff_n && wr_rdy) q.push_back(din);
      tick(1);
      check(9'(af_n), 9'(q.size() + m < 64));
      check(9'(ff_n), 9'(q.size() < 64));
    end
    wen_n = 1'b1;
    tick(3);
  endtask : push
  task automatic pop(input int n, input int e);
    ren_a_n = 1'b0;
    ren_b_n = 1'b0;
    for (int k = 0; k < n; k++) begin
      if (q.size() > 0) last = q.pop_front();
      tick(1);
      check(dout, last);
      check(9'(ef_n), 9'(q.size() > 0));
      check(9'(ae_n), 9'(q.size() > e));
    end
    ren_a_n = 1'b1;
    ren_b_n = 1'b1;
  endtask : pop
  task automatic conclude();
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  initial begin
    {rst, mrst_n, pin, wen_n, ren_a_n, ren_b_n} = 6'h3F;
    {oe_n, din, err_count, checked, lfsr} = '0;
    tick(16);
    rst = 1'b0;
    lfsr = 17'h1426B;
    check(dout, DATA_ZERO);
    check({ef_n, ae_n, ff_n, af_n}, 9'h003);
    pin = 1'b0;
    wen_n = 1'b0;
    tick(3);
    {wen_n, pin} = 2'h3;
    check(9'(ef_n), 9'h000);
    push(7, 7);
    check(9'(ae_n), 9'h000);
    push(61, 7);
    oe_n = 1'b1;
    tick(1);
    check(9'(oe), 9'h000);
    check(bus, ~dout);
    oe_n = 1'b0;
    tick(1);
    check(9'(oe), 9'h001);
    check(bus, dout);
    pop(70, 7);
    mrst_n = 1'b0;
    pin = 1'b0;
    tick(2);
    mrst_n = 1'b1;
    for (int k = 0; k < 6; k++) begin
      din = {1'b0, k == 4 ? 8'h02 : 8'h03 + 8'(k)};
      wen_n = 1'b0;
      tick(1);
    end
    {wen_n, pin} = 2'h3;
    tick(1);
    pin = 1'b0;
    for (int k = 0; k < 4; k++) begin
      {ren_a_n, ren_b_n} = 2'h0;
      tick(1);
      check(dout, k == 0 ? 9'h005 : (k == 2 ? 9'h002 : 9'h000));
    end
    {ren_a_n, ren_b_n, pin} = 3'h7;
    push(2, 5);
    check(9'(ae_n), 9'h000);
    push(62, 5);
    pop(64, 2);
    conclude();
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    conclude();
  end
endmodule : testbench
